// ==== core/ccp_pkg.sv ====
// package: register map, field layout and reset values of the clock control
`default_nettype none
package ccp_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [29:0] IDX_CLK_SETUP = 30'h0000_4000;
	localparam logic [29:0] IDX_REG_LEVEL = 30'h0000_4001;
	localparam logic [29:0] IDX_SYNTH_LO  = 30'h0000_4002;
	localparam logic [29:0] IDX_SYNTH_HI  = 30'h0000_4003;
	// clocking_setup fields
	localparam int CS_CORE_EN  = 0;
	localparam int CS_MDIV_LO  = 1;
	localparam int CS_SRC_SEL  = 3;
	localparam int CS_CLOCK_OUTPUT_PIN_EN  = 4;
	localparam int CS_MFREQ_LO = 5;
	localparam logic [7:0] CS_RST   = 8'h00;
	localparam logic [7:0] CS_WMASK = 8'h7f;
	// core_regulator_level field, reset code 01 is 1.4 V
	localparam int RL_LEVEL_LO = 1;
	localparam logic [1:0] RL_RST = 2'h1;
	// synth_parameters fields
	localparam int SP_EN     = 0;
	localparam int SP_LOCK   = 1;
	localparam int SP_TYPE   = 8;
	localparam int SP_XDIV   = 9;
	localparam int SP_INT    = 11;
	localparam int SP_NUM_LO = 16;
	localparam int SP_NUM_HI = 24;
	localparam int SP_DEN_LO = 32;
	localparam int SP_DEN_HI = 40;
	localparam logic [47:0] SP_RST   = 48'h0753_0287_1901;
	localparam logic [47:0] SP_WMASK = 48'hffff_ffff_7f01;
	// lock accepts reference periods that differ by at most this many cycles
	localparam logic [15:0] LOCK_TOL = 16'h0001;

	// divide ratio 1..4 from a two-bit code
	function automatic logic [2:0] ccp_div_of(input logic [1:0] code);
		return {1'b0, code} + 3'h1;
	endfunction
endpackage
`default_nettype wire

// ==== core/ccp_clk_if.sv ====
// interface: signals between control top, PLL model and core divider
`default_nettype none
interface ccp_clk_if;
	logic        mclk_tick;
	logic        pll_en;
	logic        pll_frac;
	logic [3:0]  int_r;
	logic [1:0]  in_div;
	logic [15:0] den_m;
	logic [15:0] num_n;
	logic        param_load;
	logic        pll_tick;
	logic        pll_locked;
	logic        src_sel;
	logic [1:0]  mclk_div;
	logic        core_en;
	logic        clock_output_pin_en;
	logic [1:0]  clock_output_pin_freq;
	logic        core_tick;
	logic        clock_output_pin_pulse;
	modport top (output mclk_tick, pll_en, pll_frac, int_r, in_div, den_m,
		num_n, param_load, src_sel, mclk_div, core_en, clock_output_pin_en, clock_output_pin_freq,
		input pll_tick, pll_locked, core_tick, clock_output_pin_pulse);
	modport pll (input mclk_tick, pll_en, pll_frac, int_r, in_div, den_m,
		num_n, param_load, output pll_tick, pll_locked);
	modport div (input mclk_tick, pll_tick, src_sel, mclk_div, core_en,
		clock_output_pin_en, clock_output_pin_freq, output core_tick, clock_output_pin_pulse);
endinterface
`default_nettype wire

// ==== core/ccp_synth.sv ====
// module: fractional/integer-N synthesiser model with sticky lock
`default_nettype none
module ccp_synth
	import ccp_pkg::*;
(
	input  wire logic clock,
	input  wire logic sys_rst,
	ccp_clk_if.pll    io
);
	typedef struct packed {
		logic [1:0]  xcnt;
		logic [15:0] ref_cnt;
		logic [15:0] period;
		logic [15:0] prev;
		logic [32:0] acc;
		logic        locked;
		logic        tick;
	} ccp_syn_s;

	ccp_syn_s    st_ff;
	ccp_syn_s    nxt_st;
	logic [15:0] m_eff;
	logic [15:0] n_eff;
	logic [19:0] step;
	logic [31:0] thr;
	logic [32:0] sum;
	logic [15:0] diff;

	assign io.pll_tick   = st_ff.tick;
	assign io.pll_locked = st_ff.locked;

	// reference measurement, lock and ratio accumulator
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		m_eff = (io.pll_frac && io.den_m != 16'h0000) ? io.den_m : 16'h0001;
		n_eff = (io.pll_frac && io.den_m != 16'h0000) ? io.num_n : 16'h0000;
		step = 20'(io.int_r) * 20'(m_eff) + 20'(n_eff);
		thr = 32'(st_ff.period) * 32'(m_eff);
		sum = st_ff.acc + 33'(step);
		diff = (st_ff.period > st_ff.prev) ? st_ff.period - st_ff.prev
			: st_ff.prev - st_ff.period;
		if (st_ff.ref_cnt != 16'hffff)
			nxt_st.ref_cnt = st_ff.ref_cnt + 16'h0001;
		if (io.mclk_tick) begin
			// input divider X before the loop
			if (3'(st_ff.xcnt) == ccp_div_of(io.in_div) - 3'h1) begin
				nxt_st.xcnt = 2'h0;
				nxt_st.ref_cnt = 16'h0001;
				nxt_st.period = st_ff.ref_cnt;
				nxt_st.prev = st_ff.period;
				if (st_ff.period != 16'h0000 && diff <= LOCK_TOL)
					nxt_st.locked = 1'b1; // sticky
			end else begin
				nxt_st.xcnt = st_ff.xcnt + 2'h1;
			end
		end
		if (st_ff.period != 16'h0000) begin
			if (sum >= 33'(thr)) begin
				nxt_st.acc = sum - 33'(thr);
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.acc = sum;
			end
		end
		// disabled or freshly loaded ratio restarts the loop
		if (!io.pll_en || io.param_load)
			nxt_st = '0;
	end

	// state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule // ccp_synth
`default_nettype wire

// ==== core/ccp_core_div.sv ====
// module: glitch-free core clock divider and clock-out rate divider
`default_nettype none
module ccp_core_div
	import ccp_pkg::*;
(
	input  wire logic clock,
	input  wire logic sys_rst,
	ccp_clk_if.div    io
);
	typedef struct packed {
		logic [1:0] cnt;
		logic [1:0] div_cur;
		logic       src_cur;
		logic [2:0] clock_output_pin_cnt;
		logic       core_tick;
		logic       clock_output_pin_pulse;
	} ccp_div_s;

	ccp_div_s   st_ff;
	ccp_div_s   nxt_st;
	logic       src;
	logic [3:0] mlim;

	assign io.core_tick  = st_ff.core_tick;
	assign io.clock_output_pin_pulse = st_ff.clock_output_pin_pulse;

	// divide the chosen source to 256 fs and then to the clock-out rate
	always_comb begin
		nxt_st = st_ff;
		nxt_st.core_tick = 1'b0;
		nxt_st.clock_output_pin_pulse = 1'b0;
		src = st_ff.src_cur ? io.pll_tick : io.mclk_tick;
		mlim = 4'h8 >> io.clock_output_pin_freq;
		if (!io.core_en) begin
			// gate stopped: settings load freely
			nxt_st.cnt = 2'h0;
			nxt_st.clock_output_pin_cnt = 3'h0;
			nxt_st.src_cur = io.src_sel;
			nxt_st.div_cur = io.mclk_div;
		end else if (src) begin
			if (3'(st_ff.cnt) == ccp_div_of(st_ff.div_cur) - 3'h1) begin
				nxt_st.cnt = 2'h0;
				nxt_st.core_tick = 1'b1;
				// new settings only at a period boundary
				nxt_st.src_cur = io.src_sel;
				nxt_st.div_cur = io.mclk_div;
				if (!io.clock_output_pin_en) begin
					nxt_st.clock_output_pin_cnt = 3'h0;
				end else if (4'(st_ff.clock_output_pin_cnt) == mlim - 4'h1) begin
					nxt_st.clock_output_pin_cnt = 3'h0;
					nxt_st.clock_output_pin_pulse = 1'b1;
				end else begin
					nxt_st.clock_output_pin_cnt = st_ff.clock_output_pin_cnt + 3'h1;
				end
			end else begin
				nxt_st.cnt = st_ff.cnt + 2'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule // ccp_core_div
`default_nettype wire

// ==== core/ccp_clock_ctrl.sv ====
// module: APB register file and top of the codec clock control
`default_nettype none
module ccp_clock_ctrl
	import ccp_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              master_clock_input_pin,
	output logic                   clock_output_pin,
	output logic                   core_clock_tick,
	output logic      [1:0]        core_supply_output,
	output logic                   pll_locked
);
	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic        sync3;
		logic [7:0]  setup;
		logic [1:0]  level;
		logic [47:0] synth;
		logic [15:0] stage_hi;
		logic        load;
		logic [31:0] rdata;
	} ccp_top_s;

	ccp_top_s  st_ff;
	ccp_top_s  nxt_st;
	ccp_clk_if cif ();
	logic      hit;
	logic      wr;
	logic      setup_ph;

	// true when the byte address is word aligned and its word address is one of the mapped registers
	function automatic logic ccp_mapped(input logic [ADDR_W-1:0] a);
		return a[1:0] == 2'h0 && (a[31:2] == IDX_CLK_SETUP
			|| a[31:2] == IDX_REG_LEVEL || a[31:2] == IDX_SYNTH_LO
			|| a[31:2] == IDX_SYNTH_HI);
	endfunction

	// apb handshake: zero wait states, error on unmapped words
	assign hit      = ccp_mapped(paddr);
	assign setup_ph = psel && !penable;
	assign wr       = psel && penable && pwrite && hit;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !hit;
	assign prdata   = st_ff.rdata;

	// register outputs toward pins
	assign clock_output_pin   = cif.clock_output_pin_pulse;
	assign core_clock_tick    = cif.core_tick;
	assign core_supply_output = st_ff.level;
	assign pll_locked         = cif.pll_locked;

	// fields toward the synthesiser, M and N joined from their bytes
	assign cif.mclk_tick  = st_ff.sync2 && !st_ff.sync3;
	assign cif.pll_en     = st_ff.synth[SP_EN];
	assign cif.pll_frac   = st_ff.synth[SP_TYPE];
	assign cif.int_r      = st_ff.synth[SP_INT+:4];
	assign cif.in_div     = st_ff.synth[SP_XDIV+:2];
	assign cif.den_m      = {st_ff.synth[SP_DEN_HI+:8],
		st_ff.synth[SP_DEN_LO+:8]};
	assign cif.num_n      = {st_ff.synth[SP_NUM_HI+:8],
		st_ff.synth[SP_NUM_LO+:8]};
	assign cif.param_load = st_ff.load;

	// fields toward the core divider
	assign cif.src_sel   = st_ff.setup[CS_SRC_SEL];
	assign cif.mclk_div  = st_ff.setup[CS_MDIV_LO+:2];
	assign cif.core_en   = st_ff.setup[CS_CORE_EN];
	assign cif.clock_output_pin_en   = st_ff.setup[CS_CLOCK_OUTPUT_PIN_EN];
	assign cif.clock_output_pin_freq = st_ff.setup[CS_MFREQ_LO+:2];

	// pll ratio model
	ccp_synth u_synth (
		.clock   (clock),
		.sys_rst (sys_rst),
		.io      (cif.pll)
	);

	// core clock and clock-out dividers
	ccp_core_div u_div (
		.clock   (clock),
		.sys_rst (sys_rst),
		.io      (cif.div)
	);

	// pin synchroniser, register writes and read data
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = master_clock_input_pin;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		nxt_st.load = 1'b0;
		if (wr) begin
			case (paddr[31:2])
				IDX_CLK_SETUP: nxt_st.setup = pwdata[7:0] & CS_WMASK;
				IDX_REG_LEVEL: nxt_st.level = pwdata[RL_LEVEL_LO+:2];
				IDX_SYNTH_HI: nxt_st.stage_hi = pwdata[15:0];
				IDX_SYNTH_LO: begin
					// last word of the burst commits all six bytes
					nxt_st.synth = {st_ff.stage_hi, pwdata} & SP_WMASK;
					nxt_st.load = 1'b1;
				end
				default: nxt_st.setup = st_ff.setup;
			endcase
		end
		if (setup_ph) begin
			case (paddr[31:2])
				IDX_CLK_SETUP: nxt_st.rdata = {24'h00_0000, st_ff.setup};
				IDX_REG_LEVEL:
					nxt_st.rdata = {29'h0, st_ff.level, 1'b0};
				IDX_SYNTH_LO: begin
					nxt_st.rdata = st_ff.synth[31:0];
					nxt_st.rdata[SP_LOCK] = cif.pll_locked;
				end
				IDX_SYNTH_HI: nxt_st.rdata = {16'h0000, st_ff.synth[47:32]};
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
			if (paddr[1:0] != 2'h0)
				nxt_st.rdata = 32'h0000_0000;
		end
	end

	// state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.setup <= CS_RST;
			st_ff.level <= RL_RST;
			st_ff.synth <= SP_RST;
			st_ff.stage_hi <= SP_RST[47:32];
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule // ccp_clock_ctrl
`default_nettype wire

// ==== tb/ccp_mclk_src.sv ====
// model: external master clock source with a stoppable square wave
`default_nettype none
module ccp_mclk_src (
	input  wire logic       clock,
	input  wire logic       run,
	input  wire logic [7:0] half,
	output var  logic       pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_ff = 8'h00;
	initial pin = 1'b0;
	// exact period of 2*half cycles, held low while stopped
	always @(posedge clock) begin
		if (!run) begin
			pin <= 1'b0;
			cnt_ff <= 8'h00;
		end else if (cnt_ff == half - 8'h01) begin
			pin <= !pin;
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule // ccp_mclk_src
`default_nettype wire

// ==== tb/ccp_clock_ctrl_checker.sv ====
// checker: register and clock output properties at the top ports
`default_nettype none
module ccp_clock_ctrl_checker
	import ccp_pkg::*;
(
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              master_clock_input_pin,
	input wire logic              clock_output_pin,
	input wire logic              core_clock_tick,
	input wire logic [1:0]        core_supply_output,
	input wire logic              pll_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A_CS = {IDX_CLK_SETUP, 2'b00};
	localparam logic [31:0] A_RL = {IDX_REG_LEVEL, 2'b00};
	localparam logic [31:0] A_LO = {IDX_SYNTH_LO, 2'b00};
	logic       wr_acc;
	logic       rd_acc;
	logic [6:0] setup_ff;
	logic [6:0] off_ff;
	logic [6:0] mo_ff;
	logic       lo_wr_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	// shadow of the setup register and idle counters of gated outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			setup_ff <= 7'h00;
			off_ff <= 7'h00;
			mo_ff <= 7'h00;
			lo_wr_ff <= 1'b0;
		end else begin
			// commit seen one cycle ago; the synthesiser clears a cycle later
			lo_wr_ff <= wr_acc && paddr == A_LO;
			if (wr_acc && paddr == A_CS)
				setup_ff <= pwdata[6:0];
			if (setup_ff[CS_CORE_EN])
				off_ff <= 7'h00;
			else if (off_ff != 7'h7f)
				off_ff <= off_ff + 7'h01;
			if (setup_ff[CS_CORE_EN] && setup_ff[CS_CLOCK_OUTPUT_PIN_EN])
				mo_ff <= 7'h00;
			else if (mo_ff != 7'h7f)
				mo_ff <= mo_ff + 7'h01;
		end
	end
	setup_read_a: assert property (rd_acc && paddr == A_CS |->
		prdata == {25'h0, setup_ff}) else $error("setup readback wrong");
	level_write_a: assert property (wr_acc && paddr == A_RL |=>
		core_supply_output == $past(pwdata[2:1]))
		else $error("regulator level not written");
	level_hold_a: assert property (!(wr_acc && paddr == A_RL) |=>
		$stable(core_supply_output)) else $error("regulator level moved");
	core_off_a: assert property (off_ff == 7'h7f |->
		!core_clock_tick) else $error("core ticks while disabled");
	clock_output_pin_off_a: assert property (mo_ff == 7'h7f |->
		!clock_output_pin) else $error("clock out while disabled");
	lock_sticky_a: assert property (pll_locked && !lo_wr_ff &&
		!(wr_acc && paddr == A_LO) |=> pll_locked) else $error("lock lost");
	lock_restart_a: assert property (lo_wr_ff |=>
		!pll_locked) else $error("lock kept after commit");
	lock_read_a: assert property (rd_acc && paddr == A_LO |->
		prdata[SP_LOCK] == $past(pll_locked))
		else $error("lock bit readback wrong");
	tick_pulse_a: assert property (core_clock_tick |=>
		!core_clock_tick) else $error("core tick too long");
	clock_output_pin_pulse_a: assert property (clock_output_pin |=>
		!clock_output_pin) else $error("clock out pulse too long");
	cover property (wr_acc && paddr == A_RL);
	cover property (rd_acc && pslverr);
	cover property ($rose(pll_locked));
	cover property (clock_output_pin);
endmodule // ccp_clock_ctrl_checker
bind ccp_clock_ctrl ccp_clock_ctrl_checker chk_i (.clock(clock),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .master_clock_input_pin(master_clock_input_pin),
	.clock_output_pin(clock_output_pin), .core_clock_tick(core_clock_tick),
	.core_supply_output(core_supply_output), .pll_locked(pll_locked));
`default_nettype wire

// ==== tb/test_codec_clock_pll_control.sv ====
// testbench: register access, clock division and synthesiser lock
`default_nettype none
module test_codec_clock_pll_control
	import ccp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A_CS = {IDX_CLK_SETUP, 2'b00};
	localparam logic [31:0] A_RL = {IDX_REG_LEVEL, 2'b00};
	localparam logic [31:0] A_LO = {IDX_SYNTH_LO, 2'b00};
	localparam logic [31:0] A_HI = {IDX_SYNTH_HI, 2'b00};
	logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic        mclk, run, co_pin, core_tick, locked;
	logic [31:0] paddr, pwdata, prdata;
	logic [1:0]  level;
	logic [32:0] expq[$];
	int          fail_count, cmp_count, i, n;
	ccp_clock_ctrl uut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.master_clock_input_pin(mclk), .clock_output_pin(co_pin),
		.core_clock_tick(core_tick), .core_supply_output(level),
		.pll_locked(locked));
	ccp_mclk_src src_i (.clock(clock), .run(run), .half(8'h04), .pin(mclk));
	always #2.5 clock = !clock;
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [31:0] a, d);
		// callers that end on a falling edge first wait for a rising one
		if (clock !== 1'b1)
			@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [31:0] a, e, input logic err);
		expq.push_back({err, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// cycles between two pulses of the tick or the clock output
	task automatic gap(input logic sel, input int exp);
		int k;
		repeat (2) begin
			k = 0;
			do begin
				@(negedge clock);
				k++;
			end while ((sel ? co_pin : core_tick) !== 1'b1 && k < 4000);
		end
		chk(33'(k), 33'(exp));
	endtask
	task automatic quiet(input logic both);
		repeat (100) @(posedge clock);
		n = 0;
		repeat (200) begin
			@(negedge clock);
			if (co_pin !== 1'b0 || (both && core_tick !== 1'b0))
				n++;
		end
		chk(33'(n), 33'h0);
	endtask
	// each completed read against the oldest note
	always @(posedge clock) begin
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0
			&& pready === 1'b1 && expq.size() > 0)
			chk({pslverr, prdata}, expq.pop_front());
	end
	initial begin
		repeat (40000) @(posedge clock);
		fail_count++;
		results();
	end
	initial begin
		{clock, psel, penable, pwrite, run} = 5'h00;
		{paddr, pwdata} = 64'h0000_0000_0000_0000;
		sys_rst = 1'b1;
		void'($urandom(32'he38d));
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(A_CS, 32'h0000_0000, 1'b0);
		rd(A_RL, 32'h0000_0002, 1'b0);
		rd(A_LO, 32'h0287_1901, 1'b0);
		rd(A_HI, 32'h0000_0753, 1'b0);
		rd(A_CS + 32'h0000_0002, 32'h0000_0000, 1'b1);
		rd(32'h0001_0010, 32'h0000_0000, 1'b1);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, A_RL, ($urandom() & 32'hffff_fff9) | 32'(i * 2));
			@(negedge clock);
			chk({31'h0, level}, 33'(i));
			rd(A_RL, 32'(i * 2), 1'b0);
		end
		apb(1'b1, A_RL, 32'h0000_0000);
		run <= 1'b1;
		for (i = 0; i < 4; i++) begin
			apb(1'b1, A_CS, ($urandom() & 32'hffff_ff80)
				| 32'(i * 34 + 17));
			repeat (200) @(posedge clock);
			gap(1'b0, 8 * (i + 1));
			gap(1'b1, 8 * (i + 1) * (8 >> i));
		end
		apb(1'b1, A_CS, 32'h0000_0001);
		quiet(1'b0);
		apb(1'b1, A_CS, 32'h0000_0010);
		quiet(1'b1);
		apb(1'b1, A_HI, 32'h0000_0001);
		apb(1'b1, A_LO, 32'h0000_1001);
		rd(A_LO, 32'h0000_1001, 1'b0);
		n = 0;
		while (locked !== 1'b1 && n < 2000) begin
			@(negedge clock);
			n++;
		end
		rd(A_LO, 32'h0000_1003, 1'b0);
		apb(1'b1, A_HI, 32'h0000_beef);
		rd(A_HI, 32'h0000_0001, 1'b0);
		apb(1'b1, A_CS, 32'h0000_007f);
		repeat (200) @(posedge clock);
		gap(1'b0, 16);
		gap(1'b1, 16);
		run <= 1'b0;
		repeat (100) @(posedge clock);
		rd(A_LO, 32'h0000_1003, 1'b0);
		apb(1'b1, A_LO, 32'h0000_1000);
		rd(A_LO, 32'h0000_1000, 1'b0);
		rd(A_HI, 32'h0000_beef, 1'b0);
		results();
	end
endmodule // test_codec_clock_pll_control
`default_nettype wire
